/* pkg/bceh_pkg.sv */
package bceh_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and bit timing.
	localparam int          CLK_NS      = 25;
	localparam int          CNT_W       = 12;
	localparam int          LOW_MIN_NS  = 2000;
	localparam int          LOW_MAX_NS  = 40000;
	localparam int          NACK_NS     = 5000;
	// Least time rounds up, longest and drive times round down.
	localparam logic [11:0] LOW_MIN_CYC = 12'((LOW_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] LOW_MAX_CYC = 12'(LOW_MAX_NS / CLK_NS);
	localparam logic [11:0] NACK_CYC    = 12'(NACK_NS / CLK_NS);
	localparam logic [11:0] CNT_ONE     = 12'h001;
	localparam logic [11:0] CNT_ZERO    = 12'h000;

	////////////////////////////////////////////////////////////////////////////////
	// Frame layout and pin levels.
	localparam int          BYTE_W      = 6;
	localparam logic [5:0]  LAST_BYTE   = 6'h1F;
	localparam logic        IDLE_LEVEL  = 1'h1;
	localparam logic        NACK_LEVEL  = 1'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic             is_tx;
		logic             bcast;
		logic             data_fld;
		logic [BYTE_W-1:0] byte_idx;
	} bceh_ctx_type;

	typedef struct packed {
		logic parity;
		logic underrun;
		logic overrun;
		logic write;
	} bceh_oerr_type;

	typedef struct packed {
		logic abort;
		logic retx;
		logic accept_retx;
	} bceh_act_type;

	typedef enum logic [1:0] {
		ST_WAIT = 2'h0,
		ST_ACT  = 2'h1,
		ST_NACK = 2'h3
	} bceh_state_type;

endpackage : bceh_pkg

/* logic/bceh_sync.sv */
module bceh_sync (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Pin side.
	input  wire logic pin_raw,
	// Filtered level.
	output logic      level
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	logic nxt_lvl;

	// The level only moves once the second and third stages agree.
	always_comb
	begin
		nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_ff  <= bceh_pkg::IDLE_LEVEL;
			s2_ff  <= bceh_pkg::IDLE_LEVEL;
			s3_ff  <= bceh_pkg::IDLE_LEVEL;
			lvl_ff <= bceh_pkg::IDLE_LEVEL;
		end
		else
		begin
			s1_ff  <= pin_raw;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level = lvl_ff;

endmodule : bceh_sync

/* logic/bceh_err.sv */
module bceh_err (
	// Clock and reset.
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	// Bus pin, driven high at NACK_LEVEL while enabled.
	input  wire logic                    bus_sense,
	output logic                         bus_drive,
	output logic                         bus_oe_n,
	// Protocol engine events.
	input  wire logic                    frame_start,
	input  wire logic                    frame_end,
	input  wire logic                    nack_seen,
	input  wire bceh_pkg::bceh_ctx_type  ctx,
	input  wire bceh_pkg::bceh_oerr_type oerr,
	// Actions and status.
	output bceh_pkg::bceh_act_type       act,
	output logic                         timing_err,
	output logic                         comm_error_irq,
	output logic                         busy
);

	bceh_pkg::bceh_state_type st_ff;
	bceh_pkg::bceh_state_type nxt_st;
	bceh_pkg::bceh_act_type   act_ff;
	bceh_pkg::bceh_act_type   nxt_act;
	logic [11:0]              low_cnt_ff;
	logic [11:0]              nxt_low_cnt;
	logic [11:0]              nack_cnt_ff;
	logic [11:0]              nxt_nack_cnt;
	logic                     prev_ff;
	logic                     irq_ff;
	logic                     nxt_irq;
	logic                     terr_ff;
	logic                     lvl;
	logic                     rise;
	logic                     tim_err;
	logic                     nack_ev;
	logic                     nack_fatal;
	logic                     nack_retx;
	logic                     send_nack;

	bceh_sync u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_raw (bus_sense),
		.level   (lvl)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Error classification.

	always_comb
	begin
		rise = lvl && !prev_ff;
		tim_err = (st_ff == bceh_pkg::ST_ACT) &&
			((rise && (low_cnt_ff < bceh_pkg::LOW_MIN_CYC)) ||
			(!lvl && (low_cnt_ff == bceh_pkg::LOW_MAX_CYC)));
		nack_ev = nack_seen && (st_ff == bceh_pkg::ST_ACT) && !ctx.bcast && !tim_err;
		nack_fatal = nack_ev && (!ctx.data_fld ||
			(ctx.is_tx && (ctx.byte_idx == bceh_pkg::LAST_BYTE)));
		nack_retx = nack_ev && !nack_fatal;
		send_nack = tim_err && !ctx.is_tx && !ctx.bcast;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb
	begin
		nxt_st       = st_ff;
		nxt_nack_cnt = nack_cnt_ff;
		// The low counter saturates so a stuck bus cannot wrap into a legal length.
		nxt_low_cnt  = bceh_pkg::CNT_ZERO;
		if (!lvl)
		begin
			nxt_low_cnt = low_cnt_ff;
			if (low_cnt_ff != 12'hFFF)
			begin
				nxt_low_cnt = low_cnt_ff + bceh_pkg::CNT_ONE;
			end
		end
		nxt_act.retx        = nack_retx && ctx.is_tx;
		nxt_act.accept_retx = nack_retx && !ctx.is_tx;
		nxt_act.abort       = tim_err || nack_fatal;
		nxt_irq = tim_err || nack_fatal || (|oerr);
		case (st_ff)
			bceh_pkg::ST_WAIT:
			begin
				if (frame_start)
				begin
					nxt_st = bceh_pkg::ST_ACT;
				end
			end
			bceh_pkg::ST_ACT:
			begin
				if (send_nack)
				begin
					nxt_st       = bceh_pkg::ST_NACK;
					nxt_nack_cnt = bceh_pkg::NACK_CYC;
				end
				else if (tim_err || nack_fatal || frame_end)
				begin
					nxt_st = bceh_pkg::ST_WAIT;
				end
			end
			bceh_pkg::ST_NACK:
			begin
				nxt_nack_cnt = nack_cnt_ff - bceh_pkg::CNT_ONE;
				if (nack_cnt_ff == bceh_pkg::CNT_ONE)
				begin
					nxt_st = bceh_pkg::ST_WAIT;
				end
			end
			default:
			begin
				nxt_st = bceh_pkg::ST_WAIT;
			end
		endcase
	end


	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff       <= bceh_pkg::ST_WAIT;
			act_ff      <= '0;
			low_cnt_ff  <= bceh_pkg::CNT_ZERO;
			nack_cnt_ff <= bceh_pkg::CNT_ZERO;
			prev_ff     <= bceh_pkg::IDLE_LEVEL;
			irq_ff      <= 1'h0;
			terr_ff     <= 1'h0;
		end
		else
		begin
			st_ff       <= nxt_st;
			act_ff      <= nxt_act;
			low_cnt_ff  <= nxt_low_cnt;
			nack_cnt_ff <= nxt_nack_cnt;
			prev_ff     <= lvl;
			irq_ff      <= nxt_irq;
			terr_ff     <= tim_err;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign act            = act_ff;
	assign timing_err     = terr_ff;
	assign comm_error_irq = irq_ff;
	assign busy           = (st_ff != bceh_pkg::ST_WAIT);
	assign bus_drive      = bceh_pkg::NACK_LEVEL;
	// Driving only from a state register keeps the pin glitch free.
	assign bus_oe_n       = (st_ff != bceh_pkg::ST_NACK);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_timing_abort_irq: assert property (tim_err |=> act_ff.abort && comm_error_irq)
		else $error("timing error did not abort with interrupt");
	a_bcast_rx_wait: assert property (tim_err && ctx.bcast && !ctx.is_tx
		|=> st_ff == bceh_pkg::ST_WAIT && bus_oe_n)
		else $error("broadcast rx timing error did not return to wait");
	a_indiv_rx_nack: assert property (tim_err && !ctx.bcast && !ctx.is_tx
		|=> (!bus_oe_n && bus_drive == bceh_pkg::NACK_LEVEL)[*8])
		else $error("individual rx timing error did not drive nack");
	a_nack_drive_ends: assert property ($rose(st_ff == bceh_pkg::ST_NACK)
		|-> ##[1:260] (st_ff == bceh_pkg::ST_WAIT))
		else $error("nack drive did not end in start wait");
	a_nack_state_quiet: assert property (st_ff == bceh_pkg::ST_NACK
		|=> !act_ff.abort && !act_ff.retx && !act_ff.accept_retx)
		else $error("event acted on during nack drive");
	a_tx_timing_wait: assert property (tim_err && ctx.is_tx
		|=> st_ff == bceh_pkg::ST_WAIT && bus_oe_n)
		else $error("tx timing error did not return to wait");
	a_bcast_nack_none: assert property (nack_seen && ctx.bcast && !tim_err && !(|oerr)
		|=> !act_ff.abort && !act_ff.retx && !act_ff.accept_retx && !comm_error_irq)
		else $error("broadcast nack caused an action");
	a_hdr_nack_abort: assert property (nack_seen && !ctx.bcast && !ctx.data_fld
		&& st_ff == bceh_pkg::ST_ACT && !tim_err
		|=> act_ff.abort && comm_error_irq && st_ff == bceh_pkg::ST_WAIT)
		else $error("nack outside data did not abort");
	a_data_nack_retx: assert property (nack_retx && !(|oerr) && !frame_end
		|=> !comm_error_irq && (act_ff.retx ^ act_ff.accept_retx)
		&& st_ff == bceh_pkg::ST_ACT)
		else $error("data nack not handled by retransmission");
	a_last_byte_abort: assert property (nack_ev && ctx.data_fld && ctx.is_tx
		&& ctx.byte_idx == bceh_pkg::LAST_BYTE
		|=> act_ff.abort && comm_error_irq && st_ff == bceh_pkg::ST_WAIT)
		else $error("nack on last byte did not abort");
	a_irq_or_all: assert property (|oerr |=> comm_error_irq)
		else $error("other error did not raise interrupt");
	a_irq_needs_err: assert property (!tim_err && !nack_seen && !(|oerr)
		|=> !comm_error_irq)
		else $error("interrupt raised without an error");
	a_timing_flag_out: assert property (tim_err |=> timing_err)
		else $error("timing error flag not raised");

	c_bcast_timing: cover property (tim_err && ctx.bcast);
	c_indiv_nack_out: cover property (st_ff == bceh_pkg::ST_NACK ##1 st_ff == bceh_pkg::ST_WAIT);
	c_data_retx: cover property (nack_retx && ctx.is_tx);
	c_last_byte: cover property (nack_fatal && ctx.data_fld);
	c_bcast_nack: cover property (nack_seen && ctx.bcast && st_ff == bceh_pkg::ST_ACT);

endmodule : bceh_err

/* bench/bceh_peer.sv */
// Another unit on the bus: pulls the line low for len cycles per go.
module bceh_peer (
	// Clock.
	input  wire logic        clk_sys,
	// Command.
	input  wire logic        go,
	input  wire logic [11:0] len,
	// Bus level, released high by the pull-up.
	output logic             line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] left_ff = 12'h000;
	assign line = (left_ff == 12'h000);
	always @(posedge clk_sys)
	begin
		if (go)
			left_ff <= len;
		else if (left_ff != 12'h000)
			left_ff <= left_ff - 12'h001;
	end
endmodule : bceh_peer

/* bench/bceh_err_bench.sv */
module bceh_err_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk_sys = 1'h0;
	logic                    rstn = 1'h0;
	logic                    frame_start = 1'h0;
	logic                    frame_end = 1'h0;
	logic                    nack_seen = 1'h0;
	logic                    p_go = 1'h0;
	logic [11:0]             p_len = 12'h000;
	logic [11:0]             drv = 12'h000;
	logic [4:0]              seen = 5'h00;
	bceh_pkg::bceh_ctx_type  ctx = '0;
	bceh_pkg::bceh_oerr_type oerr = '0;
	bceh_pkg::bceh_act_type  act;
	logic                    bus_drive;
	logic                    bus_oe_n;
	logic                    timing_err;
	logic                    comm_error_irq;
	logic                    busy;
	logic                    p_line;
	logic                    bus_line;
	int                      n_errors = 0;
	int                      tests_run = 0;
	always #12.5 clk_sys = ~clk_sys;
	// Our NACK drive wins over the released line.
	assign bus_line = bus_oe_n ? p_line : bus_drive;
	bceh_peer u_peer (.clk_sys(clk_sys), .go(p_go), .len(p_len), .line(p_line));
	bceh_err u_dut (.clk_sys(clk_sys), .rstn(rstn), .bus_sense(bus_line),
		.bus_drive(bus_drive), .bus_oe_n(bus_oe_n), .frame_start(frame_start),
		.frame_end(frame_end), .nack_seen(nack_seen), .ctx(ctx), .oerr(oerr), .act(act),
		.timing_err(timing_err), .comm_error_irq(comm_error_irq), .busy(busy));
	// Pulses are gathered sticky so their exact cycle does not matter.
	always @(negedge clk_sys)
	begin
		seen <= seen | {timing_err, comm_error_irq, act.abort, act.retx, act.accept_retx};
		if (bus_oe_n === 1'h0 && bus_drive === bceh_pkg::NACK_LEVEL)
			drv <= drv + 12'h001;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [11:0] got, logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic tick(int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic start(logic [8:0] c);
		@(posedge clk_sys);
		seen = 5'h00;
		drv = 12'h000;
		@(negedge clk_sys);
		ctx = c;
		frame_start = 1'h1;
		tick(1);
		frame_start = 1'h0;
		tick(2);
	endtask : start
	task automatic nack();
		nack_seen = 1'h1;
		tick(1);
		nack_seen = 1'h0;
		tick(4);
	endtask : nack
	task automatic fin();
		frame_end = 1'h1;
		tick(1);
		frame_end = 1'h0;
		tick(3);
	endtask : fin
	task automatic low(logic [11:0] n);
		p_len = n;
		p_go = 1'h1;
		tick(1);
		p_go = 1'h0;
		tick(int'(n) + 12);
	endtask : low
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_hdr_nack();
		start(9'h100);
		nack();
		chk("tx hdr nack", {seen, busy}, 12'h018);
		start(9'h000);
		nack();
		chk("rx hdr nack", {seen, busy}, 12'h018);
	endtask : s_hdr_nack
	task automatic s_data_nack();
		start(9'h143);
		nack();
		chk("tx data nack", {seen, busy}, 12'h005);
		fin();
		chk("end busy", busy, 12'h000);
		start(9'h05F);
		nack();
		chk("rx byte 32 nack", {seen, busy}, 12'h003);
		fin();
		start(9'h15F);
		nack();
		chk("tx byte 32 nack", {seen, busy}, 12'h018);
	endtask : s_data_nack
	task automatic s_bcast_nack();
		start(9'h180);
		nack();
		chk("bcast nack", {seen, busy}, 12'h001);
		fin();
	endtask : s_bcast_nack
	task automatic s_rx_short();
		start(9'h000);
		low(12'h014);
		tick(200);
		chk("rx short", {seen, busy}, 12'h038);
		chk("nack drive", drv, 12'(bceh_pkg::NACK_CYC));
	endtask : s_rx_short
	task automatic s_bcast_long();
		start(9'h0A2);
		low(12'h064);
		chk("legal low", {seen, busy}, 12'h001);
		low(12'h6A4);
		chk("bcast long", {seen, busy}, 12'h038);
		chk("bcast no drive", drv, 12'h000);
	endtask : s_bcast_long
	task automatic s_tx_timing();
		start(9'h100);
		low(12'h014);
		chk("tx timing", {seen, busy, drv[3:0]}, 12'h380);
	endtask : s_tx_timing
	task automatic s_oerr();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			seen = 5'h00;
			@(negedge clk_sys);
			oerr = 4'h1 << i;
			tick(1);
			oerr = 4'h0;
			tick(4);
			chk("other error irq", seen, 12'h008);
		end
	endtask : s_oerr
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#500us;
		n_errors++;
		close_out();
	end
	initial
	begin
		tick(6);
		rstn = 1'h1;
		tick(6);
		s_hdr_nack();
		s_data_nack();
		s_bcast_nack();
		s_rx_short();
		s_bcast_long();
		s_tx_timing();
		s_oerr();
		close_out();
	end
endmodule : bceh_err_bench
